/* core/gptc_pkg.sv */
// constants shared by the timer block and its bus front end
package gptc_pkg;

    // byte offsets of the registers on the bus
    localparam logic [7:0] GPTC_OFS_AUX_A_TIMER = 8'h00;
    localparam logic [7:0] GPTC_OFS_CORE_TIMER = 8'h04;
    localparam logic [7:0] GPTC_OFS_AUX_B_TIMER = 8'h08;
    localparam logic [7:0] GPTC_OFS_AUX_A_CTL = 8'h10;
    localparam logic [7:0] GPTC_OFS_CORE_CTL = 8'h14;
    localparam logic [7:0] GPTC_OFS_AUX_B_CTL = 8'h18;

    // timer indices, also the order of the register groups
    localparam int GPTC_AUX_A = 0;
    localparam int GPTC_CORE = 1;
    localparam int GPTC_AUX_B = 2;
    localparam int GPTC_NUM = 3;

    // widths
    localparam int GPTC_CNT_W = 16;
    localparam int GPTC_CTL_W = 12;
    localparam int GPTC_PRE_W = 10;

    // control register field positions
    localparam int GPTC_ISEL_LSB = 0;
    localparam int GPTC_MODE_LSB = 3;
    localparam int GPTC_RUN_BIT = 6;
    localparam int GPTC_DIR_BIT = 7;
    localparam int GPTC_EXTDIR_BIT = 8;
    localparam int GPTC_OE_RR_BIT = 9;
    localparam int GPTC_OTL_BIT = 10;
    localparam int GPTC_FAST_BIT = 11;

    // reset values and writable masks
    localparam logic [GPTC_CNT_W-1:0] GPTC_CNT_RST = 16'h0000;
    localparam logic [GPTC_CTL_W-1:0] GPTC_CTL_RST = 12'h000;
    localparam logic [GPTC_CTL_W-1:0] GPTC_CORE_CTL_MASK = 12'hFFF;
    localparam logic [GPTC_CTL_W-1:0] GPTC_AUX_CTL_MASK = 12'hBFF;

    // mode field codes
    localparam logic [2:0] GPTC_MODE_TIMER = 3'h0;
    localparam logic [2:0] GPTC_MODE_COUNTER = 3'h1;
    localparam logic [1:0] GPTC_MODE_GATED_HI = 2'h1;
    localparam logic [1:0] GPTC_MODE_INCR_HI = 2'h3;

    // prescaler exponents: factor is two to this power
    localparam logic [3:0] GPTC_PRE_FAST_EXP = 4'h2;
    localparam logic [3:0] GPTC_PRE_BASE_EXP = 4'h3;

    // bus constants
    localparam logic [1:0] GPTC_HTRANS_NONSEQ_BIT = 2'h2;
    localparam logic [2:0] GPTC_HSIZE_WORD = 3'h2;

endpackage

/* core/gptc_ahb_slave.sv */
// ahb-lite front end: captures address phases, one wait state on reads
`timescale 1ns/10ps
`default_nettype none
module gptc_ahb_slave
    import gptc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    output logic reg_wr,
    output logic [7:0] reg_addr,
    output logic [31:0] reg_wdata,
    input wire logic [31:0] reg_rdata
);

    typedef struct packed {
        logic wr_pend;
        logic rd_pend;
        logic rd_done;
        logic [7:0] addr;
        logic [31:0] rdata;
    } gptc_bus_t;

    gptc_bus_t s_q;
    gptc_bus_t s_d;
    logic take;

    // only whole-word transfers with htrans[1] set, nonsequential or sequential, are taken
    assign take = hsel && htrans[1] && (hsize == GPTC_HSIZE_WORD);

    // the read wait state lets hrdata come from a flop with current data
    always_comb begin
        s_d = s_q;
        if (s_q.rd_pend && !s_q.rd_done) begin
            s_d.rd_done = 1'b1;
            s_d.rdata = reg_rdata;
        end else if (hready) begin
            s_d.rd_done = 1'b0;
            s_d.wr_pend = take && hwrite;
            s_d.rd_pend = take && !hwrite;
            s_d.addr = haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign hreadyout = !(s_q.rd_pend && !s_q.rd_done);
    assign hrdata = s_q.rdata;
    assign hresp = 1'b0; // always okay
    assign reg_wr = s_q.wr_pend;
    assign reg_addr = s_q.addr;
    assign reg_wdata = hwdata;

endmodule
`default_nettype wire

/* core/gptc_timer_block.sv */
// timer block: core timer and two auxiliary timers behind ahb-lite
//
// Design decisions made here: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module gptc_timer_block
    import gptc_pkg::*;
#(
    parameter int CNT_W = GPTC_CNT_W
)
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    input wire logic count_input,
    input wire logic direction_input,
    input wire logic aux_a_count_input,
    input wire logic aux_a_direction_input,
    input wire logic aux_b_count_input,
    input wire logic aux_b_direction_input,
    output logic toggle_output_line
);

    localparam int NP = 2 * GPTC_NUM;

    // whole state of the block
    typedef struct packed {
        logic [NP-1:0] sync1;
        logic [NP-1:0] sync2;
        logic [NP-1:0] prev;
        logic [GPTC_PRE_W-1:0] presc;
        logic [GPTC_NUM-1:0][CNT_W-1:0] cnt;
        logic [GPTC_NUM-1:0][GPTC_CTL_W-1:0] ctl;
        logic tog_out;
    } gptc_state_t;

    gptc_state_t s_q;
    gptc_state_t s_d;

    logic reg_wr;
    logic [7:0] reg_addr;
    logic [31:0] reg_wdata;
    logic [31:0] reg_rdata;

    logic [NP-1:0] pins;
    logic [GPTC_NUM-1:0] step;
    logic [GPTC_NUM-1:0] down;
    logic [GPTC_NUM-1:0] run_eff;
    logic [GPTC_NUM-1:0] wr_cnt;
    logic [GPTC_NUM-1:0] wr_ctl;
    logic core_wrap;
    logic otl_q;
    logic otl_rise;
    logic otl_fall;

    // register decode, shared by the write and read paths
    // result: bit 3 valid, bit 2 control group, bits 1:0 timer index
    function automatic logic [3:0] gptc_decode(input logic [7:0] a);
        logic [3:0] r;
        r = 4'h0;
        if (a == GPTC_OFS_AUX_A_TIMER) begin
            r = 4'h8;
        end else if (a == GPTC_OFS_CORE_TIMER) begin
            r = 4'h9;
        end else if (a == GPTC_OFS_AUX_B_TIMER) begin
            r = 4'hA;
        end else if (a == GPTC_OFS_AUX_A_CTL) begin
            r = 4'hC;
        end else if (a == GPTC_OFS_CORE_CTL) begin
            r = 4'hD;
        end else if (a == GPTC_OFS_AUX_B_CTL) begin
            r = 4'hE;
        end
        return r;
    endfunction

    // prescaler tick: the free counter's low bits are all zero once per factor
    function automatic logic gptc_tick(
        input logic [GPTC_PRE_W-1:0] p,
        input logic fast,
        input logic [2:0] isel
    );
        logic [3:0] e;
        logic [GPTC_PRE_W-1:0] m;
        e = (fast && (isel == 3'h0)) ? GPTC_PRE_FAST_EXP
                                     : GPTC_PRE_BASE_EXP + {1'b0, isel};
        m = ~(10'h3FF << e);
        return (p & m) == 10'h000;
    endfunction

    // bus front end
    gptc_ahb_slave u_bus (
        .hclk(hclk),
        .hresetn(hresetn),
        .hsel(hsel),
        .haddr(haddr),
        .htrans(htrans),
        .hwrite(hwrite),
        .hsize(hsize),
        .hwdata(hwdata),
        .hready(hready),
        .hreadyout(hreadyout),
        .hrdata(hrdata),
        .hresp(hresp),
        .reg_wr(reg_wr),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_rdata(reg_rdata)
    );

    // pin order: count inputs then direction inputs, by timer index
    assign pins = {aux_b_direction_input, direction_input, aux_a_direction_input,
                   aux_b_count_input, count_input, aux_a_count_input};

    // toggle latch edges seen by the auxiliaries come only from core wraps,
    // so software writes of the latch never clock them
    assign otl_q = s_q.ctl[GPTC_CORE][GPTC_OTL_BIT];
    assign core_wrap = step[GPTC_CORE] && !wr_cnt[GPTC_CORE] &&
                       (down[GPTC_CORE] ? (s_q.cnt[GPTC_CORE] == '0)
                                        : (s_q.cnt[GPTC_CORE] == '1));
    assign otl_rise = core_wrap && !otl_q;
    assign otl_fall = core_wrap && otl_q;

    // per-timer step and direction
    for (genvar i = 0; i < GPTC_NUM; i++) begin : g_tmr
        logic [2:0] mode;
        logic [2:0] isel;
        logic tick;
        logic in_lvl;
        logic in_rise;
        logic in_fall;
        logic ud_lvl;
        logic ud_rise;
        logic ud_fall;
        logic edge_sel;
        logic src_rise;
        logic src_fall;
        logic inc_in;
        logic inc_ud;

        assign mode = s_q.ctl[i][GPTC_MODE_LSB +: 3];
        assign isel = s_q.ctl[i][GPTC_ISEL_LSB +: 3];
        assign tick = gptc_tick(s_q.presc, s_q.ctl[i][GPTC_FAST_BIT], isel);

        // only the second flop and its delayed copy are looked at
        assign in_lvl = s_q.sync2[i];
        assign in_rise = s_q.sync2[i] && !s_q.prev[i];
        assign in_fall = !s_q.sync2[i] && s_q.prev[i];
        assign ud_lvl = s_q.sync2[i+GPTC_NUM];
        assign ud_rise = s_q.sync2[i+GPTC_NUM] && !s_q.prev[i+GPTC_NUM];
        assign ud_fall = !s_q.sync2[i+GPTC_NUM] && s_q.prev[i+GPTC_NUM];

        // auxiliaries may count toggle latch edges; the core has no such source
        if (i == GPTC_CORE) begin : g_core_src
            assign src_rise = isel[2] ? 1'b0 : in_rise;
            assign src_fall = isel[2] ? 1'b0 : in_fall;
        end else begin : g_aux_src
            assign src_rise = isel[2] ? otl_rise : in_rise;
            assign src_fall = isel[2] ? otl_fall : in_fall;
        end
        assign edge_sel = (isel[0] && src_rise) || (isel[1] && src_fall);

        // incremental: select 01 count line, 10 direction line, 11 both
        assign inc_in = isel[0] && (in_rise || in_fall);
        assign inc_ud = isel[1] && (ud_rise || ud_fall);

        // remote run for auxiliaries follows the core run bit
        if (i == GPTC_CORE) begin : g_core_run
            assign run_eff[i] = s_q.ctl[i][GPTC_RUN_BIT];
        end else begin : g_aux_run
            assign run_eff[i] = s_q.ctl[i][GPTC_OE_RR_BIT]
                                ? s_q.ctl[GPTC_CORE][GPTC_RUN_BIT]
                                : s_q.ctl[i][GPTC_RUN_BIT];
        end

        // gates are plain levels here; nothing in this block raises interrupts
        always_comb begin
            step[i] = 1'b0;
            down[i] = s_q.ctl[i][GPTC_EXTDIR_BIT]
                      ? (ud_lvl ^ s_q.ctl[i][GPTC_DIR_BIT])
                      : s_q.ctl[i][GPTC_DIR_BIT];
            if (mode == GPTC_MODE_TIMER) begin
                step[i] = run_eff[i] && tick;
            end else if (mode == GPTC_MODE_COUNTER) begin
                step[i] = run_eff[i] && edge_sel;
            end else if (mode[2:1] == GPTC_MODE_GATED_HI) begin
                step[i] = run_eff[i] && tick && (in_lvl == mode[0]);
            end else if (mode[2:1] == GPTC_MODE_INCR_HI) begin
                step[i] = run_eff[i] && (inc_in || inc_ud);
                down[i] = inc_in ? (in_rise ? ud_lvl : !ud_lvl)
                                 : (ud_rise ? !in_lvl : in_lvl);
            end
        end

        // write strobes for this timer's two registers
        assign wr_cnt[i] = reg_wr && (gptc_decode(reg_addr) == {2'b10, 2'(i)});
        assign wr_ctl[i] = reg_wr && (gptc_decode(reg_addr) == {2'b11, 2'(i)});
    end

    // read mux; bits above each register's width read as zero
    always_comb begin
        logic [3:0] d;
        d = gptc_decode(reg_addr);
        reg_rdata = 32'h0000_0000;
        if (d[3] && !d[2] && (d[1:0] != 2'h3)) begin
            reg_rdata = {{(32-CNT_W){1'b0}}, s_q.cnt[d[1:0]]};
        end else if (d[3] && d[2] && (d[1:0] != 2'h3)) begin
            reg_rdata = {{(32-GPTC_CTL_W){1'b0}}, s_q.ctl[d[1:0]]};
        end
    end

    // next state of synchronisers, prescaler, counts and controls
    always_comb begin
        s_d = s_q;
        s_d.sync1 = pins;
        s_d.sync2 = s_q.sync1;
        s_d.prev = s_q.sync2;
        s_d.presc = s_q.presc + 10'h001;

        for (int i = 0; i < GPTC_NUM; i++) begin
            // a software write replaces the count and drops the step
            if (wr_cnt[i]) begin
                s_d.cnt[i] = reg_wdata[CNT_W-1:0];
            end else if (step[i] && down[i]) begin
                s_d.cnt[i] = s_q.cnt[i] - 1'b1;
            end else if (step[i]) begin
                s_d.cnt[i] = s_q.cnt[i] + 1'b1;
            end

            if (wr_ctl[i]) begin
                s_d.ctl[i] = reg_wdata[GPTC_CTL_W-1:0] &
                             ((i == GPTC_CORE) ? GPTC_CORE_CTL_MASK : GPTC_AUX_CTL_MASK);
            end
        end

        // a wrap in the same cycle as a write still toggles the written value
        s_d.ctl[GPTC_CORE][GPTC_OTL_BIT] =
            (wr_ctl[GPTC_CORE] ? reg_wdata[GPTC_OTL_BIT] : otl_q) ^ core_wrap;

        // output line is registered so it changes one edge after the latch
        s_d.tog_out = s_q.ctl[GPTC_CORE][GPTC_OE_RR_BIT] && otl_q;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            s_q.sync1 <= '0;
            s_q.sync2 <= '0;
            s_q.prev <= '0;
            s_q.presc <= '0;
            s_q.cnt <= {GPTC_NUM{GPTC_CNT_RST}};
            s_q.ctl <= {GPTC_NUM{GPTC_CTL_RST}};
            s_q.tog_out <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    assign toggle_output_line = s_q.tog_out;

endmodule
`default_nettype wire

/* bench/gptc_timer_block_checker.sv */
// bus and toggle pin assertions for the timer block
`timescale 1ns/10ps
`default_nettype none
module gptc_timer_block_checker
    import gptc_pkg::*;
(
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic hreadyout,
    input wire logic [31:0] hrdata,
    input wire logic hresp,
    input wire logic toggle_output_line
);
    logic tk, rd, wr;
    logic [7:0] a;
    // accepted address phases, split by direction
    assign tk = hsel && hready && htrans[1] && (hsize == GPTC_HSIZE_WORD);
    assign rd = tk && !hwrite;
    assign wr = tk && hwrite;
    assign a = haddr[7:0];
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    resp_okay_a: assert property (hresp == 1'b0)
        else $error("bus response not okay");
    rd_wait_a: assert property (rd |=> !hreadyout ##1 hreadyout)
        else $error("read wait state wrong");
    wr_nowait_a: assert property (wr |=> hreadyout)
        else $error("write stalled");
    cnt_width_a: assert property (rd && a < 8'h0C |-> ##2 hrdata[31:16] == 16'h0000)
        else $error("count wider than 16 bits");
    ctl_width_a: assert property (rd && a[4] |-> ##2 hrdata[31:12] == 20'h00000)
        else $error("control upper bits set");
    aux_otl_a: assert property (rd && a[4] && a[3:0] != 4'h4 |-> ##2 !hrdata[10])
        else $error("aux control shows toggle bit");
    unmapped_a: assert property (rd && a > 8'h18 |-> ##2 hrdata == 32'h0)
        else $error("unmapped read not zero");
    hold_data_a: assert property (hreadyout && $past(hreadyout) |-> $stable(hrdata))
        else $error("read data moved");
    toggle_off_a: assert property (
        wr && a == GPTC_OFS_CORE_CTL ##1 !hwdata[9] |-> ##2 !toggle_output_line)
        else $error("toggle line driven while disabled");
    // main traffic seen
    cover property (wr);
    cover property (rd);
    cover property ($rose(toggle_output_line));
endmodule
bind gptc_timer_block gptc_timer_block_checker u_chk (.hclk(hclk), .hresetn(hresetn),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp), .toggle_output_line(toggle_output_line));
`default_nettype wire

/* bench/gptc_pin_model.sv */
// pin side model: count/gate and direction lines of the three timers
`timescale 1ns/10ps
`default_nettype none
module gptc_pin_model (
    input wire logic hclk,
    output logic [2:0] cnt_pin,
    output logic [2:0] dir_pin
);
    // lines idle low
    initial begin
        cnt_pin = 3'h0;
        dir_pin = 3'h0;
    end
    // each level held 4 clocks so no edge is lost in the synchronisers
    task automatic pulse(input int t, input int n);
        repeat (2 * n) begin
            @(posedge hclk);
            cnt_pin[t] <= ~cnt_pin[t];
            repeat (3) @(posedge hclk);
        end
        repeat (4) @(posedge hclk);
    endtask
    // direction line, settled before any count edge
    task automatic set_dir(input int t, input logic v);
        @(posedge hclk);
        dir_pin[t] <= v;
        repeat (4) @(posedge hclk);
    endtask
endmodule
`default_nettype wire

/* bench/tb.sv */
// self-checking bench for the timer block
`timescale 1ns/10ps
`default_nettype none
module tb
    import gptc_pkg::*;
;
    logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, tog, ok;
    logic [31:0] haddr, hwdata, hrdata, rdv, rv, c1;
    logic [1:0] htrans;
    logic [2:0] hsize, cnt_pin, dir_pin, c;
    wire logic hready;
    int err_count, total_checks, seed, n;
    assign hready = hreadyout;
    gptc_timer_block #(.CNT_W(GPTC_CNT_W)) u_gptc_timer_block (.hclk(hclk), .hresetn(hresetn),
        .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
        .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
        .hresp(hresp), .count_input(cnt_pin[1]), .direction_input(dir_pin[1]),
        .aux_a_count_input(cnt_pin[0]), .aux_a_direction_input(dir_pin[0]),
        .aux_b_count_input(cnt_pin[2]), .aux_b_direction_input(dir_pin[2]),
        .toggle_output_line(tog));
    gptc_pin_model u_gptc_pin_model (.hclk(hclk), .cnt_pin(cnt_pin), .dir_pin(dir_pin));
    // 20 MHz clock
    initial begin
        hclk = 1'b0;
        forever #25 hclk = ~hclk;
    end
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // single word transfer; waits on hready, never on a fixed count
    task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        htrans <= 2'h2;
        hwrite <= w;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= wd;
        do @(posedge hclk); while (hreadyout !== 1'b1);
        rdv = hrdata;
    endtask
    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check(nm, rdv, e);
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask
    // control word: isel, mode, run, dir, ext, bit9, toggle bit, fast
    function automatic logic [31:0] ctl(logic [2:0] i, logic [2:0] m, logic r, logic d,
        logic e, logic b9, logic o, logic f);
        return {20'h0, f, o, b9, e, d, r, m, i};
    endfunction
    function automatic int pre(logic f, logic [2:0] i);
        return (f && i == 3'h0) ? 4 : 8 << i;
    endfunction
    // hang guard
    initial begin
        repeat (20000) @(posedge hclk);
        err_count++;
        close_out();
    end
    initial begin
        {hsel, haddr, htrans, hwrite, hwdata} = '0;
        hsize = GPTC_HSIZE_WORD;
        hresetn = 1'b0;
        err_count = 0;
        total_checks = 0;
        seed = 75038;
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        // reset values, and one unmapped place
        for (int i = 0; i < 7; i++) rd_chk("reset", 8'(i * 4 + (i / 3) * 4), 32'h0);
        // random counts read back through every timer
        for (int i = 0; i < 9; i++) begin
            rv = $random(seed);
            bus(1'b1, 8'((i % 3) * 4), rv);
            rd_chk("count", 8'((i % 3) * 4), {16'h0, rv[15:0]});
        end
        // core counter edge select; selects with top bit set stay unused
        for (int i = 0; i < 4; i++) begin
            bus(1'b1, GPTC_OFS_CORE_TIMER, 32'h0);
            bus(1'b1, GPTC_OFS_CORE_CTL, ctl(3'(i), 3'h1, 1, 0, 0, 0, 0, 0));
            u_gptc_pin_model.pulse(1, 3);
            n = (i == 0) ? 0 : (i == 3) ? 6 : 3;
            rd_chk("edges", GPTC_OFS_CORE_TIMER, 32'(n));
        end
        // direction table on each timer: c = {ext, dir bit, pin}
        for (int t = 0; t < 3; t++) begin
            for (int k = 0; k < 8; k++) begin
                c = 3'(k);
                u_gptc_pin_model.set_dir(t, c[0]);
                bus(1'b1, 8'(t * 4), 32'h0100);
                bus(1'b1, 8'(t * 4 + 16), ctl(3'h1, 3'h1, 1, c[1], c[2], 0, 0, 0));
                u_gptc_pin_model.pulse(t, 2);
                rv = (c[2] ? c[0] ^ c[1] : c[1]) ? 32'h00FE : 32'h0102;
                rd_chk("direction", 8'(t * 4), rv);
            end
        end
        // wraps toggle the latch, which feeds aux_a and the pin
        bus(1'b1, GPTC_OFS_AUX_A_TIMER, 32'h0);
        bus(1'b1, GPTC_OFS_AUX_A_CTL, ctl(3'h5, 3'h1, 1, 0, 0, 0, 0, 0));
        bus(1'b1, GPTC_OFS_CORE_TIMER, 32'hFFFF);
        c1 = ctl(3'h1, 3'h1, 1, 0, 0, 1, 0, 0);
        bus(1'b1, GPTC_OFS_CORE_CTL, c1);
        u_gptc_pin_model.pulse(1, 1);
        rd_chk("overflow", GPTC_OFS_CORE_TIMER, 32'h0);
        rd_chk("toggle set", GPTC_OFS_CORE_CTL, c1 | 32'h400);
        check("line", {31'h0, tog}, 32'h1);
        rd_chk("aux chained", GPTC_OFS_AUX_A_TIMER, 32'h1);
        bus(1'b1, GPTC_OFS_CORE_CTL, c1 | 32'h480);
        u_gptc_pin_model.pulse(1, 1);
        rd_chk("underflow", GPTC_OFS_CORE_TIMER, 32'hFFFF);
        rd_chk("toggle clr", GPTC_OFS_CORE_CTL, c1 | 32'h80);
        check("line", {31'h0, tog}, 32'h0);
        // software set of the latch must not clock aux_a
        bus(1'b1, GPTC_OFS_CORE_CTL, c1 | 32'h400);
        repeat (4) @(posedge hclk);
        check("line", {31'h0, tog}, 32'h1);
        rd_chk("aux chained", GPTC_OFS_AUX_A_TIMER, 32'h1);
        // prescaled timer and gated modes; aux_b runs from the core run bit
        for (int k = 0; k < 6; k++) begin
            c = (k < 4) ? 3'h0 : 3'(k - 2);
            rv = (k == 1 || k == 2 || k == 3) ? 32'(k - 1) : 32'h0;
            bus(1'b1, GPTC_OFS_CORE_CTL, 32'h0);
            bus(1'b1, GPTC_OFS_CORE_TIMER, 32'h0);
            bus(1'b1, GPTC_OFS_AUX_B_TIMER, 32'h0);
            bus(1'b1, GPTC_OFS_AUX_B_CTL, ctl(rv[2:0], c, 0, 0, 0, 1, 0, k != 1 && k < 4));
            bus(1'b1, GPTC_OFS_CORE_CTL, ctl(rv[2:0], c, 1, 0, 0, 0, 0, k != 1 && k < 4));
            repeat (125) @(posedge hclk);
            bus(1'b1, GPTC_OFS_CORE_CTL, ctl(rv[2:0], c, 0, 0, 0, 0, 0, 0));
            n = (k == 5) ? 0 : 128 / pre(k != 1 && k < 4, rv[2:0]);
            for (int t = 1; t < 3; t++) begin
                bus(1'b0, 8'(t * 4), 32'h0);
                ok = (rdv >= 32'(n > 0 ? n - 1 : 0)) && (rdv <= 32'(n > 0 ? n + 1 : 0));
                check("prescaled count", {31'h0, ok}, 32'h1);
            end
        end
        // incremental mode on direction line edges, count line held low
        u_gptc_pin_model.set_dir(1, 1'b1);
        bus(1'b1, GPTC_OFS_CORE_TIMER, 32'h0010);
        bus(1'b1, GPTC_OFS_CORE_CTL, ctl(3'h2, 3'h6, 1, 0, 1, 0, 0, 0));
        u_gptc_pin_model.set_dir(1, 1'b0);
        rd_chk("incr fall up", GPTC_OFS_CORE_TIMER, 32'h0011);
        u_gptc_pin_model.set_dir(1, 1'b1);
        rd_chk("incr rise down", GPTC_OFS_CORE_TIMER, 32'h0010);
        bus(1'b1, GPTC_OFS_CORE_CTL, 32'h0);
        close_out();
    end
endmodule
`default_nettype wire
